// ===== design/aws_rate_ctrl.sv
// Auto-wake/sleep sample-rate controller with interrupt pin control
`timescale 1ns/100ps
`include "aws_cfg.svh"

module aws_rate_ctrl
	import aws_pkg::*;
#(
	parameter logic [23:0] PER_AM0 = 24'(`AWS_US2CYC(`AWS_T_AM0_US)),
	parameter logic [23:0] PER_AM1 = 24'(`AWS_US2CYC(`AWS_T_AM1_US)),
	parameter logic [23:0] PER_AM2 = 24'(`AWS_US2CYC(`AWS_T_AM2_US)),
	parameter logic [23:0] PER_AM3 = 24'(`AWS_US2CYC(`AWS_T_AM3_US)),
	parameter logic [23:0] PER_AM4 = 24'(`AWS_US2CYC(`AWS_T_AM4_US)),
	parameter logic [23:0] PER_AM5 = 24'(`AWS_US2CYC(`AWS_T_AM5_US)),
	parameter logic [23:0] PER_AM6 = 24'(`AWS_US2CYC(`AWS_T_AM6_US)),
	parameter logic [23:0] PER_AM7 = 24'(`AWS_US2CYC(`AWS_T_AM7_US)),
	parameter logic [23:0] PER_AW3 = 24'(`AWS_US2CYC(`AWS_T_AW3_US))
) (
	input  wire logic         ref_clk,
	input  wire logic         rate_status_register,
	input  wire logic         ce,
	input  wire aws_reg_req_t reg_req,
	input  wire logic         addr_ack,
	input  wire logic [7:0]   irq_src,
	input  wire aws_axes_t    fast_avg,
	input  wire aws_axes_t    slow_avg,
	output logic [7:0]        reg_rdata,
	output logic              irq_o,
	output logic              irq_oe,
	output logic              sample_tick,
	output logic              tap_tick,
	output logic              tap_hit,
	output logic              wake_rate_active_flag,
	output logic              active_rate_active_flag
);
	localparam logic [11:0] TAP_CYC = 12'(`AWS_US2CYC(`AWS_T_TAP_US));

	aws_state_t  st_r, st_nxt;
	logic [7:0]  mode_r, mode_nxt;
	logic [7:0]  sleep_max_count_r, sleep_max_count_nxt;
	logic [7:0]  int_setup_r, int_setup_nxt;
	logic [7:0]  sample_rate_select_r, sample_rate_select_nxt;
	logic [4:0]  tap_threshold_field_r, tap_threshold_field_nxt;
	logic [7:0]  rdata_r, rdata_nxt;
	logic [7:0]  sleep_cnt_r, sleep_cnt_nxt;
	logic [3:0]  presc_r, presc_nxt;
	logic        pend_r, pend_nxt;
	logic        irq_o_r, irq_o_nxt;
	logic        irq_oe_r, irq_oe_nxt;
	logic        hit_r, hit_nxt;
	logic        wflag_r, wflag_nxt;
	logic        aflag_r, aflag_nxt;

	logic [2:0]  active_rate_field;
	logic [1:0]  wake_rate_field;
	logic [23:0] period;
	logic        restart;
	logic        smp;
	logic        tap_smp;
	logic        sleep_reset;
	logic        sleep_tick;
	logic        timeout;
	logic        sel_irq;
	logic        irq_set;
	logic        level;
	logic [2:0]  axis_hit;
	logic [7:0]  fast_v [3];
	logic [7:0]  slow_v [3];

	assign active_rate_field = sample_rate_select_r[2:0];
	assign wake_rate_field   = sample_rate_select_r[4:3];

	assign reg_rdata               = rdata_r;
	assign irq_o                   = irq_o_r;
	assign irq_oe                  = irq_oe_r;
	assign sample_tick             = smp;
	assign tap_tick                = tap_smp;
	assign tap_hit                 = hit_r;
	assign wake_rate_active_flag   = wflag_r;
	assign active_rate_active_flag = aflag_r;

	// Period of the rate currently in use
	always_comb begin
		if (st_r == AWS_ST_WAKE) begin
			case (wake_rate_field)
				2'h0:    period = PER_AM2;
				2'h1:    period = PER_AM3;
				2'h2:    period = PER_AM4;
				default: period = PER_AW3;
			endcase
		end else begin
			case (active_rate_field)
				3'h0:    period = PER_AM0;
				3'h1:    period = PER_AM1;
				3'h2:    period = PER_AM2;
				3'h3:    period = PER_AM3;
				3'h4:    period = PER_AM4;
				3'h5:    period = PER_AM5;
				3'h6:    period = PER_AM6;
				default: period = PER_AM7;
			endcase
		end
	end

	// A state change restarts the sample period rather than finishing the old one
	assign restart = (st_r == AWS_ST_STANDBY) || (st_nxt != st_r);

	aws_rate_timer #(
		.W(24)
	) u_smp_timer (
		.ref_clk(ref_clk),
		.rate_status_register   (rate_status_register),
		.ce     (ce),
		.restart(restart),
		.period (period),
		.tick   (smp)
	);

	// fast tap-filter sampling only at code 000
	aws_rate_timer #(
		.W(12)
	) u_tap_timer (
		.ref_clk(ref_clk),
		.rate_status_register   (rate_status_register),
		.ce     (ce),
		.restart(restart || (st_r == AWS_ST_WAKE) || (active_rate_field != `AWS_TAP_CODE)),
		.period (TAP_CYC),
		.tick   (tap_smp)
	);

	assign fast_v[0] = fast_avg.x;
	assign fast_v[1] = fast_avg.y;
	assign fast_v[2] = fast_avg.z;
	assign slow_v[0] = slow_avg.x;
	assign slow_v[1] = slow_avg.y;
	assign slow_v[2] = slow_avg.z;

	for (genvar a = 0; a < 3; a++) begin : g_axis
		assign axis_hit[a] = ((fast_v[a] > slow_v[a]) ? (fast_v[a] - slow_v[a])
			: (slow_v[a] - fast_v[a])) > {3'h0, tap_threshold_field_r};
	end

	// sleep count write, mode write or read restart sleep timing
	assign sleep_reset = (reg_req.wr && (reg_req.addr == `AWS_OFS_SLEEP_CNT))
		|| ((reg_req.wr || reg_req.rd) && (reg_req.addr == `AWS_OFS_MODE));
	assign sleep_tick = smp && (!mode_r[`AWS_MODE_PRESCALE]
		|| (presc_r == 4'(`AWS_PRESCALE_DIV - 1)));
	// count of 0 gives the full 256 ticks through wrap-around
	assign timeout = (st_r == AWS_ST_SLEEP) && !sleep_reset && sleep_tick
		&& (8'(sleep_cnt_r + 8'h01) == sleep_max_count_r);
	// enabled sources interrupt; sleep-exit bit masked out here
	assign sel_irq = |(irq_src & int_setup_r & ~(8'h01 << `AWS_INT_SLEEP_EXIT));
	// sleep-exit interrupt gated by its enable
	assign irq_set = sel_irq || (timeout && int_setup_r[`AWS_INT_SLEEP_EXIT]);

	// Mode state machine
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			AWS_ST_STANDBY: begin
				// enter at active rate, sleep first when enabled
				if (mode_r[`AWS_MODE_ACTIVE] && !mode_r[`AWS_MODE_TEST])
					st_nxt = mode_r[`AWS_MODE_SLEEP_EN] ? AWS_ST_SLEEP : AWS_ST_ACTIVE;
			end
			AWS_ST_ACTIVE: begin
				// active rate kept with no timeout
				st_nxt = AWS_ST_ACTIVE;
			end
			AWS_ST_SLEEP: begin
				// timeout falls back to wake rate
				if (timeout)
					st_nxt = AWS_ST_WAKE;
			end
			AWS_ST_WAKE: begin
				// selected interrupt ends auto-wake; general update excluded
				if (mode_r[`AWS_MODE_WAKE_EN]
					&& |(irq_src & int_setup_r & ~(8'h01 << `AWS_INT_GEN)
					& ~(8'h01 << `AWS_INT_SLEEP_EXIT)))
					st_nxt = mode_r[`AWS_MODE_SLEEP_EN] ? AWS_ST_SLEEP : AWS_ST_ACTIVE;
			end
			default: st_nxt = AWS_ST_STANDBY;
		endcase
		if (!mode_r[`AWS_MODE_ACTIVE])
			st_nxt = AWS_ST_STANDBY;
	end

	// Registers, sleep counter and interrupt pin
	always_comb begin
		mode_nxt                = mode_r;
		sleep_max_count_nxt     = sleep_max_count_r;
		int_setup_nxt           = int_setup_r;
		sample_rate_select_nxt  = sample_rate_select_r;
		tap_threshold_field_nxt = tap_threshold_field_r;
		rdata_nxt               = rdata_r;
		sleep_cnt_nxt           = sleep_cnt_r;
		presc_nxt               = presc_r;
		if (reg_req.wr) begin
			case (reg_req.addr)
				`AWS_OFS_SLEEP_CNT: sleep_max_count_nxt     = reg_req.wdata;
				`AWS_OFS_INT_SETUP: int_setup_nxt           = reg_req.wdata;
				`AWS_OFS_MODE:      mode_nxt                = reg_req.wdata & 8'hfd;
				`AWS_OFS_RATE_SEL:  sample_rate_select_nxt  = reg_req.wdata;
				`AWS_OFS_TAP_DET:   tap_threshold_field_nxt = reg_req.wdata[4:0];
				default:            mode_nxt                = mode_r;
			endcase
		end
		if (reg_req.rd) begin
			case (reg_req.addr)
				`AWS_OFS_RATE_STAT: rdata_nxt = {6'h00, wflag_r, aflag_r};
				`AWS_OFS_SLEEP_CNT: rdata_nxt = sleep_max_count_r;
				`AWS_OFS_INT_SETUP: rdata_nxt = int_setup_r;
				`AWS_OFS_MODE:      rdata_nxt = mode_r;
				`AWS_OFS_RATE_SEL:  rdata_nxt = sample_rate_select_r;
				`AWS_OFS_TAP_DET:   rdata_nxt = {3'h0, tap_threshold_field_r};
				default:            rdata_nxt = 8'h00;
			endcase
		end
		if (sleep_reset || st_r != AWS_ST_SLEEP) begin
			sleep_cnt_nxt = 8'h00;
			presc_nxt     = 4'h0;
		end else if (smp) begin
			presc_nxt = 4'(presc_r + 4'h1);
			if (sleep_tick)
				sleep_cnt_nxt = 8'(sleep_cnt_r + 8'h01);
		end
		// acknowledge releases; a new event in the same cycle wins
		pend_nxt = irq_set || (pend_pending_hold(pend_r, addr_ack));
		level = pend_nxt ? mode_r[`AWS_MODE_POL] : !mode_r[`AWS_MODE_POL];
		// push-pull always drives; open-drain only pulls low
		irq_oe_nxt = mode_r[`AWS_MODE_DRIVE] || !level;
		irq_o_nxt  = mode_r[`AWS_MODE_DRIVE] ? level : 1'b0;
		hit_nxt    = tap_smp ? |axis_hit : hit_r;
		wflag_nxt  = (st_nxt == AWS_ST_WAKE);
		aflag_nxt  = (st_nxt == AWS_ST_SLEEP) || (st_nxt == AWS_ST_ACTIVE);
	end

	function automatic logic pend_pending_hold(input logic p, input logic ack);
		pend_pending_hold = p && !ack;
	endfunction

	always_ff @(posedge ref_clk) begin
		if (rate_status_register) begin
			st_r                  <= AWS_ST_STANDBY;
			mode_r                <= `AWS_RST_BYTE;
			sleep_max_count_r     <= `AWS_RST_BYTE;
			int_setup_r           <= `AWS_RST_BYTE;
			sample_rate_select_r  <= `AWS_RST_BYTE;
			tap_threshold_field_r <= 5'h00;
			rdata_r               <= `AWS_RST_BYTE;
			sleep_cnt_r           <= 8'h00;
			presc_r               <= 4'h0;
			pend_r                <= 1'b0;
			irq_o_r               <= 1'b0;
			irq_oe_r              <= 1'b0;
			hit_r                 <= 1'b0;
			wflag_r               <= 1'b0;
			aflag_r               <= 1'b0;
		end else if (ce) begin
			st_r                  <= st_nxt;
			mode_r                <= mode_nxt;
			sleep_max_count_r     <= sleep_max_count_nxt;
			int_setup_r           <= int_setup_nxt;
			sample_rate_select_r  <= sample_rate_select_nxt;
			tap_threshold_field_r <= tap_threshold_field_nxt;
			rdata_r               <= rdata_nxt;
			sleep_cnt_r           <= sleep_cnt_nxt;
			presc_r               <= presc_nxt;
			pend_r                <= pend_nxt;
			irq_o_r               <= irq_o_nxt;
			irq_oe_r              <= irq_oe_nxt;
			hit_r                 <= hit_nxt;
			wflag_r               <= wflag_nxt;
			aflag_r               <= aflag_nxt;
		end
	end
endmodule

// ===== design/aws_cfg.svh
// Offsets, field positions, reset values and timing counts of the rate controller
`ifndef AWS_CFG_SVH
`define AWS_CFG_SVH

`define AWS_CLK_MHZ        10
`define AWS_US2CYC(us)     ((us) * `AWS_CLK_MHZ)

`define AWS_OFS_RATE_STAT  8'h04
`define AWS_OFS_SLEEP_CNT  8'h05
`define AWS_OFS_INT_SETUP  8'h06
`define AWS_OFS_MODE       8'h07
`define AWS_OFS_RATE_SEL   8'h08
`define AWS_OFS_TAP_DET    8'h09

`define AWS_RST_BYTE       8'h00

`define AWS_MODE_ACTIVE    0
`define AWS_MODE_TEST      2
`define AWS_MODE_WAKE_EN   3
`define AWS_MODE_SLEEP_EN  4
`define AWS_MODE_PRESCALE  5
`define AWS_MODE_DRIVE     6
`define AWS_MODE_POL       7

`define AWS_INT_GEN        4
`define AWS_INT_SLEEP_EXIT 3

`define AWS_TAP_CODE       3'h0
`define AWS_PRESCALE_DIV   16

`define AWS_T_AM0_US       8360
`define AWS_T_AM1_US       15625
`define AWS_T_AM2_US       31250
`define AWS_T_AM3_US       62500
`define AWS_T_AM4_US       125000
`define AWS_T_AM5_US       250000
`define AWS_T_AM6_US       500000
`define AWS_T_AM7_US       1000000
`define AWS_T_AW3_US       1000000
`define AWS_T_TAP_US       260

`endif

// ===== design/aws_pkg.sv
// Types shared by the auto-wake/sleep rate controller
package aws_pkg;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} aws_reg_req_t;

	typedef struct packed {
		logic [7:0] x;
		logic [7:0] y;
		logic [7:0] z;
	} aws_axes_t;

	typedef enum logic [1:0] {
		AWS_ST_STANDBY,
		AWS_ST_ACTIVE,
		AWS_ST_SLEEP,
		AWS_ST_WAKE
	} aws_state_t;

endpackage

// ===== design/aws_rate_timer.sv
// Periodic tick generator with restart
`timescale 1ns/100ps
module aws_rate_timer #(
	parameter int W = 24
) (
	input  wire logic         ref_clk,
	input  wire logic         rate_status_register,
	input  wire logic         ce,
	input  wire logic         restart,
	input  wire logic [W-1:0] period,
	output logic              tick
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic         tick_r;
	logic         tick_nxt;

	assign tick = tick_r;

	always_comb begin
		cnt_nxt  = cnt_r + 1'b1;
		tick_nxt = 1'b0;
		if (restart) begin
			cnt_nxt = '0;
		end else if (cnt_nxt >= period) begin
			cnt_nxt  = '0;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rate_status_register) begin
			cnt_r  <= '0;
			tick_r <= 1'b0;
		end else if (ce) begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end
endmodule

// ===== verif/aws_rate_ctrl_assertions.sv
// Port-level assertions for the rate controller
`timescale 1ns/100ps
`include "aws_cfg.svh"
module aws_rate_ctrl_chk
	import aws_pkg::*;
(
	input wire logic         ref_clk,
	input wire logic         rate_status_register,
	input wire logic         ce,
	input wire aws_reg_req_t reg_req,
	input wire logic         addr_ack,
	input wire logic [7:0]   irq_src,
	input wire aws_axes_t    fast_avg,
	input wire aws_axes_t    slow_avg,
	input wire logic [7:0]   reg_rdata,
	input wire logic         irq_o,
	input wire logic         irq_oe,
	input wire logic         sample_tick,
	input wire logic         tap_tick,
	input wire logic         tap_hit,
	input wire logic         wake_rate_active_flag,
	input wire logic         active_rate_active_flag
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rate_status_register);
	logic [7:0]  mode_r, int_en_r, rate_r;
	logic [4:0]  thr_r;
	logic [11:0] tcnt_r;
	logic        tseen_r, irq_act, irq_evt;
	// A released open-drain line is pulled high
	assign irq_act = (irq_oe ? irq_o : 1'b1) == mode_r[`AWS_MODE_POL];
	// Sleep-exit enable is excluded: that source is generated inside
	assign irq_evt = |(irq_src & int_en_r & 8'hf7);
	function automatic logic [7:0] ad(input logic [7:0] a, input logic [7:0] b);
		return a > b ? a - b : b - a;
	endfunction
	always_ff @(posedge ref_clk) begin
		if (rate_status_register) begin
			{mode_r, int_en_r, rate_r, thr_r, tcnt_r, tseen_r} <= '0;
		end else if (ce) begin
			if (reg_req.wr && reg_req.addr == `AWS_OFS_MODE) mode_r <= reg_req.wdata;
			if (reg_req.wr && reg_req.addr == `AWS_OFS_INT_SETUP) int_en_r <= reg_req.wdata;
			if (reg_req.wr && reg_req.addr == `AWS_OFS_RATE_SEL) rate_r <= reg_req.wdata;
			if (reg_req.wr && reg_req.addr == `AWS_OFS_TAP_DET) thr_r <= reg_req.wdata[4:0];
			tcnt_r <= tap_tick ? 12'h000 : tcnt_r + 12'h001;
			// Any write may restart the tap timer, so spacing is judged afresh
			tseen_r <= reg_req.wr ? 1'b0 : (tap_tick | tseen_r);
		end
	end
	property p_flag_excl;
		!(wake_rate_active_flag && active_rate_active_flag);
	endproperty
	a_flag_excl: assert property (p_flag_excl) else $error("both rate flags set");
	property p_od;
		!mode_r[6] && !$past(mode_r[6]) |-> !(irq_oe && irq_o);
	endproperty
	a_od: assert property (p_od) else $error("open-drain pin drove high");
	property p_pp;
		mode_r[6] && $past(mode_r[6]) |-> irq_oe;
	endproperty
	a_pp: assert property (p_pp) else $error("push-pull pin not driven");
	property p_raise;
		ce && irq_evt |=> irq_act;
	endproperty
	a_raise: assert property (p_raise) else $error("enabled event gave no pin level");
	property p_release;
		ce && addr_ack && !irq_evt |=> !irq_act;
	endproperty
	a_release: assert property (p_release) else $error("pin held after address ack");
	property p_tap_gate;
		tap_tick |-> rate_r[2:0] == `AWS_TAP_CODE && !wake_rate_active_flag;
	endproperty
	a_tap_gate: assert property (p_tap_gate) else $error("tap tick at wrong rate");
	property p_tap_gap;
		tap_tick && tseen_r |-> tcnt_r == 12'ha27;
	endproperty
	a_tap_gap: assert property (p_tap_gap) else $error("tap tick spacing wrong");
	property p_tap_hit;
		tap_tick |=> tap_hit == (ad($past(fast_avg.x), $past(slow_avg.x)) > thr_r
			|| ad($past(fast_avg.y), $past(slow_avg.y)) > thr_r
			|| ad($past(fast_avg.z), $past(slow_avg.z)) > thr_r);
	endproperty
	a_tap_hit: assert property (p_tap_hit) else $error("tap result wrong");
	property p_entry;
		$rose(mode_r[0]) && !mode_r[2] |-> ##[1:3] active_rate_active_flag;
	endproperty
	a_entry: assert property (p_entry) else $error("active entry not at active rate");
endmodule

bind aws_rate_ctrl aws_rate_ctrl_chk u_chk (.ref_clk, .rate_status_register, .ce, .reg_req, .addr_ack,
	.irq_src, .fast_avg, .slow_avg, .reg_rdata, .irq_o, .irq_oe, .sample_tick, .tap_tick,
	.tap_hit, .wake_rate_active_flag, .active_rate_active_flag);

// ===== verif/aws_host_model.sv
// Host side of the register bus and address phase
`timescale 1ns/100ps
module aws_host_model
	import aws_pkg::*;
(
	input  wire logic    ref_clk,
	output aws_reg_req_t reg_req,
	output logic         addr_ack
);
	initial begin
		reg_req = '0;
		addr_ack = 1'b0;
	end
	// Released lines show inverted data so stale values cannot pass
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_req = '{wr: w, rd: ~w, addr: a, wdata: d};
		@(negedge ref_clk);
		reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic ack();
		@(negedge ref_clk);
		addr_ack = 1'b1;
		@(negedge ref_clk);
		addr_ack = 1'b0;
	endtask
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the rate controller
`timescale 1ns/100ps
`include "aws_cfg.svh"
module tb_top
	import aws_pkg::*;
;
	localparam logic [23:0] PER [8] = '{24'h14, 24'h18, 24'h1c, 24'h20,
		24'h24, 24'h28, 24'h2c, 24'h30};
	localparam logic [7:0]  SMAX [3] = '{8'h03, 8'h00, 8'h01};
	localparam logic [7:0]  MD [3]  = '{8'h19, 8'h19, 8'h39};
	localparam logic [15:0] NT [3]  = '{16'h0003, 16'h0100, 16'h0010};
	logic         ref_clk, rate_status_register, ce, addr_ack, irq_o, irq_oe, rd_d;
	logic         sample_tick, tap_tick, tap_hit;
	logic         wake_rate_active_flag, active_rate_active_flag;
	logic [7:0]   irq_src, reg_rdata, v;
	aws_axes_t    fast_avg, slow_avg;
	aws_reg_req_t reg_req;
	logic [7:0]   exp_q[$];
	int           num_errors, checks_done, n;
	aws_rate_ctrl #(
		.PER_AM0(PER[0]), .PER_AM1(PER[1]), .PER_AM2(PER[2]), .PER_AM3(PER[3]),
		.PER_AM4(PER[4]), .PER_AM5(PER[5]), .PER_AM6(PER[6]), .PER_AM7(PER[7]),
		.PER_AW3(24'h34)
	) DUT (
		.ref_clk, .rate_status_register, .ce, .reg_req, .addr_ack, .irq_src, .fast_avg, .slow_avg,
		.reg_rdata, .irq_o, .irq_oe, .sample_tick, .tap_tick, .tap_hit,
		.wake_rate_active_flag, .active_rate_active_flag
	);
	aws_host_model host (.ref_clk, .reg_req, .addr_ack);
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		checks_done++;
		if (seen !== want) begin
			num_errors++;
			$display("BAD t=%0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cyc(input int c);
		repeat (c) @(negedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] want);
		exp_q.push_back(want);
		host.xfer(1'b0, a, 8'h00);
	endtask
	task automatic pulse(input logic [7:0] b);
		@(negedge ref_clk) irq_src = b;
		@(negedge ref_clk) irq_src = 8'h00;
	endtask
	task automatic pin(input logic [7:0] m, input logic act);
		logic lvl;
		lvl = act ? m[7] : ~m[7];
		check({14'h0, irq_oe, irq_oe & irq_o}, {14'h0, m[6] | ~lvl, m[6] & lvl});
	endtask
	task automatic flg(input logic [1:0] w);
		check({14'h0, wake_rate_active_flag, active_rate_active_flag}, {14'h0, w});
	endtask
	// Waits for one tick, then measures up to the next
	task automatic period(output int p);
		for (int j = 0; j < 2; j++) begin
			p = 0;
			do begin
				cyc(1);
				p++;
			end while (sample_tick !== 1'b1 && p < 5000);
		end
	endtask
	// Read data is registered, so it is compared one edge after the strobe
	always @(posedge ref_clk) begin
		if (rd_d) check({8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
		rd_d <= reg_req.rd;
	end
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		#4000000;
		num_errors++;
		print_verdict();
	end
	initial begin
		{rate_status_register, ce, irq_src, fast_avg, slow_avg} = {2'b11, 56'h0};
		void'($urandom(20768));
		cyc(16);
		rate_status_register = 1'b0;
		rd(`AWS_OFS_RATE_SEL, `AWS_RST_BYTE);
		v = 8'($urandom);
		host.xfer(1'b1, `AWS_OFS_RATE_SEL, v);
		rd(`AWS_OFS_RATE_SEL, v);
		rd(8'h0a, 8'h00);
		host.xfer(1'b1, `AWS_OFS_MODE, 8'h06);
		rd(`AWS_OFS_MODE, 8'h04);
		host.xfer(1'b1, `AWS_OFS_INT_SETUP, 8'h01);
		for (int i = 0; i < 4; i++) begin
			v = {i[1:0], 6'h00};
			host.xfer(1'b1, `AWS_OFS_MODE, v);
			host.ack();
			cyc(2);
			pin(v, 1'b0);
			pulse(8'h02);
			pin(v, 1'b0);
			pulse(8'h01);
			pin(v, 1'b1);
			host.ack();
			pin(v, 1'b0);
		end
		host.xfer(1'b1, `AWS_OFS_INT_SETUP, 8'h09);
		host.xfer(1'b1, `AWS_OFS_RATE_SEL, 8'h01);
		for (int i = 0; i < 3; i++) begin
			host.xfer(1'b1, `AWS_OFS_MODE, 8'h00);
			host.ack();
			host.xfer(1'b1, `AWS_OFS_SLEEP_CNT, SMAX[i]);
			host.xfer(1'b1, `AWS_OFS_MODE, MD[i]);
			cyc(2);
			flg(2'b01);
			n = 0;
			for (int k = 0; k < 8000 && active_rate_active_flag === 1'b1; k++) begin
				n += int'(sample_tick === 1'b1);
				cyc(1);
			end
			check(16'(n), NT[i]);
			flg(2'b10);
			pin(8'h00, 1'b1);
		end
		period(n);
		check(16'(n), PER[2][15:0]);
		pulse(8'h01);
		cyc(2);
		flg(2'b01);
		for (int c = 0; c < 8; c++) begin
			host.xfer(1'b1, `AWS_OFS_MODE, 8'h00);
			host.xfer(1'b1, `AWS_OFS_RATE_SEL, 8'(c));
			host.xfer(1'b1, `AWS_OFS_MODE, 8'h01);
			period(n);
			check(16'(n), PER[c][15:0]);
		end
		// Frozen cycles must stretch the sample period by exactly their number
		ce = 1'b0;
		cyc(10);
		ce = 1'b1;
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (sample_tick !== 1'b1 && n < 5000);
		check(16'(n), PER[7][15:0]);
		host.xfer(1'b1, `AWS_OFS_MODE, 8'h00);
		// Tap sampling only runs at the fastest rate code
		host.xfer(1'b1, `AWS_OFS_RATE_SEL, 8'h00);
		v = 8'($urandom) & 8'h1f;
		host.xfer(1'b1, `AWS_OFS_TAP_DET, v);
		host.xfer(1'b1, `AWS_OFS_MODE, 8'h01);
		repeat (3) begin
			fast_avg = 24'($urandom);
			// Small differences so that hits and misses both occur
			slow_avg = fast_avg ^ (24'($urandom) & 24'h3f3f3f);
			for (int k = 0; k < 3000 && tap_tick !== 1'b1; k++) cyc(1);
			cyc(1);
			check({15'h0, tap_hit}, {15'h0, (fast_avg.x > slow_avg.x ? fast_avg.x - slow_avg.x
				: slow_avg.x - fast_avg.x) > v || (fast_avg.y > slow_avg.y ? fast_avg.y
				- slow_avg.y : slow_avg.y - fast_avg.y) > v || (fast_avg.z > slow_avg.z ?
				fast_avg.z - slow_avg.z : slow_avg.z - fast_avg.z) > v});
		end
		host.xfer(1'b1, `AWS_OFS_MODE, 8'h00);
		host.xfer(1'b1, `AWS_OFS_MODE, 8'h09);
		cyc(500);
		flg(2'b01);
		rd(`AWS_OFS_RATE_STAT, 8'h01);
		cyc(2);
		print_verdict();
	end
endmodule
